//--- hw/dbs_sram_dev.sv
// Burst SRAM device end: command capture, four-beat read and write bursts, echo clocks.
// Assumes all pins are synchronous to clk_sys and the clock pairs toggle once per cycle.
// Notes on behaviour
// - Delay loop off while its pin is low.
// - Select high reads, low writes.
// - New cycle only when load strobe low.
// - Narrow part: active-low masks guard each nybble.
// - Narrow part: controller aligns lowest burst bit.
// - All inputs sampled on main input clocks.
// - Output timing clocks, else main clocks.
// - Read data aligned with echo clocks.
// - Addresses registered on main clock rising edges.
// - One address bus for reads and writes.
// - Fixed four-beat sequential burst counter.
// - Read captures its address at main rise.
// - Each read returns four organization-wide words.
// - First word on the complementary edge after the next main rise.
// - Reads every burst stream without gaps.
// - Deselect finishes burst, then outputs float.
// - Echo clocks toggle all the time.
// - Echo clocks complementary, same path as data.
// - Controller gives each bank its own load.
// - Wider parts: active-low mask per byte lane.
// - Array holds the organization's word count.
// - Burst counter wraps modulo four linearly.
// - Write at main rise with select low.
`timescale 1ns/1ps
`default_nettype none
module dbs_sram_dev #(
  parameter int DATA_W = dbs_pkg::DATA_W,
  parameter int MASK_W = dbs_pkg::MASK_W,
  parameter int DEPTH = dbs_pkg::WORDS_X8,
  parameter int ADDR_W = dbs_pkg::ADDR_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  dbs_bus_if.dev bus,
  output logic dll_locked,
  output logic single_clk_mode
);
  import dbs_pkg::*;

  localparam int LANE_W = DATA_W / MASK_W;

  // Sized by DEPTH so each organization gets its own word count.
  logic [DATA_W-1:0] mem [DEPTH];

  logic k_p_d_reg;
  logic k_n_d_reg;
  logic out_p_d_reg;
  logic out_n_d_reg;
  logic mode_caught_reg;
  logic single_reg;
  logic out_p;
  logic out_n;
  logic k_rise;
  logic in_edge;
  logic out_edge;
  logic load_cmd;
  logic rd_cmd;
  logic wr_cmd;

  // The clock mode is a strap: caught once, on the first edge after reset.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_caught_reg <= 1'b0;
      single_reg <= 1'b0;
    end else if (!mode_caught_reg) begin
      mode_caught_reg <= 1'b1;
      single_reg <= bus.output_timing_p & bus.output_timing_n;
    end
  end

  assign single_clk_mode = single_reg;
  assign out_p = single_reg ? bus.main_input_p : bus.output_timing_p;
  assign out_n = single_reg ? bus.main_input_n : bus.output_timing_n;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      k_p_d_reg <= 1'b0;
      k_n_d_reg <= 1'b1;
      out_p_d_reg <= 1'b0;
      out_n_d_reg <= 1'b1;
    end else begin
      k_p_d_reg <= bus.main_input_p;
      k_n_d_reg <= bus.main_input_n;
      out_p_d_reg <= out_p;
      out_n_d_reg <= out_n;
    end
  end

  assign k_rise = bus.main_input_p & ~k_p_d_reg;
  assign in_edge = k_rise | (bus.main_input_n & ~k_n_d_reg);
  assign out_edge = (out_p & ~out_p_d_reg) | (out_n & ~out_n_d_reg);
  assign load_cmd = k_rise & ~bus.load_strobe_b;
  assign rd_cmd = load_cmd & bus.read_write_select;
  assign wr_cmd = load_cmd & ~bus.read_write_select;

  // Read commands wait here for the launch edge; the slots let a new command
  // arrive while the previous burst is still streaming.
  logic [RD_LEAD_EDGES-1:0] rd_pipe_v_reg;
  logic [ADDR_W-1:0] rd_pipe_a_reg [RD_LEAD_EDGES];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_pipe_v_reg <= '0;
      for (int i = 0; i < RD_LEAD_EDGES; i++) begin
        rd_pipe_a_reg[i] <= '0;
      end
    end else begin
      if (out_edge) begin
        rd_pipe_v_reg <= {rd_pipe_v_reg[RD_LEAD_EDGES-2:0], 1'b0};
        for (int i = 1; i < RD_LEAD_EDGES; i++) begin
          rd_pipe_a_reg[i] <= rd_pipe_a_reg[i-1];
        end
      end
      if (rd_cmd) begin
        rd_pipe_v_reg[0] <= 1'b1;
        rd_pipe_a_reg[0] <= bus.address_pins;
      end
    end
  end

  logic rd_start;
  logic [ADDR_W-1:0] rd_start_a;
  logic rd_act_reg;
  logic [BEAT_W-1:0] rd_beat_reg;
  logic [BEAT_W-1:0] rd_ofs_reg;
  logic [ADDR_W-1:0] rd_base_reg;
  logic [ADDR_W-1:0] rd_addr;

  assign rd_start = out_edge & rd_pipe_v_reg[RD_LEAD_EDGES-1];
  assign rd_start_a = rd_pipe_a_reg[RD_LEAD_EDGES-1];
  assign rd_addr = rd_start ? rd_start_a : {rd_base_reg[ADDR_W-1:BEAT_W], rd_ofs_reg};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_act_reg <= 1'b0;
      rd_beat_reg <= '0;
      rd_ofs_reg <= '0;
      rd_base_reg <= '0;
    end else if (out_edge) begin
      if (rd_start) begin
        // A queued burst takes over on the edge after the last beat, so reads stream gaplessly.
        rd_act_reg <= 1'b1;
        rd_beat_reg <= BEAT_W'(1);
        rd_base_reg <= rd_start_a;
        rd_ofs_reg <= rd_start_a[BEAT_W-1:0] + BEAT_W'(1);
      end else if (rd_act_reg) begin
        rd_beat_reg <= rd_beat_reg + BEAT_W'(1);
        rd_ofs_reg <= rd_ofs_reg + BEAT_W'(1);
        if (rd_beat_reg == BEAT_W'(BURST_LEN - 1)) begin
          rd_act_reg <= 1'b0;
        end
      end
    end
  end

  logic [DATA_W-1:0] dq_o_reg;
  logic dq_oe_reg;
  logic cq_p_reg;
  logic cq_n_reg;

  // Data and echo clocks leave through the same register stage so they stay aligned.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dq_o_reg <= '0;
      dq_oe_reg <= 1'b0;
      cq_p_reg <= 1'b0;
      cq_n_reg <= 1'b1;
    end else begin
      cq_p_reg <= out_p;
      cq_n_reg <= out_n;
      if (out_edge) begin
        dq_oe_reg <= rd_start | rd_act_reg;
        if (rd_start | rd_act_reg) begin
          dq_o_reg <= mem[rd_addr];
        end
      end
    end
  end

  assign bus.data_dev_o = dq_o_reg;
  assign bus.data_dev_oe = dq_oe_reg;
  assign bus.echo_strobe_p = cq_p_reg;
  assign bus.echo_strobe_n = cq_n_reg;

  // Late write: beats are taken on the input edges after the one following the command.
  logic [WR_LEAD_EDGES-1:0] wr_pipe_v_reg;
  logic [ADDR_W-1:0] wr_pipe_a_reg [WR_LEAD_EDGES];
  logic wr_start;
  logic wr_act_reg;
  logic [BEAT_W-1:0] wr_beat_reg;
  logic [BEAT_W-1:0] wr_ofs_reg;
  logic [ADDR_W-1:0] wr_base_reg;
  logic [ADDR_W-1:0] wr_addr;
  logic wr_en;
  logic [DATA_W-1:0] wr_word;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_pipe_v_reg <= '0;
      for (int i = 0; i < WR_LEAD_EDGES; i++) begin
        wr_pipe_a_reg[i] <= '0;
      end
    end else begin
      if (in_edge) begin
        wr_pipe_v_reg <= {wr_pipe_v_reg[WR_LEAD_EDGES-2:0], 1'b0};
        for (int i = 1; i < WR_LEAD_EDGES; i++) begin
          wr_pipe_a_reg[i] <= wr_pipe_a_reg[i-1];
        end
      end
      if (wr_cmd) begin
        wr_pipe_v_reg[0] <= 1'b1;
        wr_pipe_a_reg[0] <= bus.address_pins;
      end
    end
  end

  assign wr_start = in_edge & wr_pipe_v_reg[WR_LEAD_EDGES-1];
  assign wr_addr = wr_start ? wr_pipe_a_reg[WR_LEAD_EDGES-1] : {wr_base_reg[ADDR_W-1:BEAT_W], wr_ofs_reg};
  assign wr_en = in_edge & (wr_start | wr_act_reg);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_act_reg <= 1'b0;
      wr_beat_reg <= '0;
      wr_ofs_reg <= '0;
      wr_base_reg <= '0;
    end else if (in_edge) begin
      if (wr_start) begin
        wr_act_reg <= 1'b1;
        wr_beat_reg <= BEAT_W'(1);
        wr_base_reg <= wr_addr;
        wr_ofs_reg <= wr_addr[BEAT_W-1:0] + BEAT_W'(1);
      end else if (wr_act_reg) begin
        wr_beat_reg <= wr_beat_reg + BEAT_W'(1);
        wr_ofs_reg <= wr_ofs_reg + BEAT_W'(1);
        if (wr_beat_reg == BEAT_W'(BURST_LEN - 1)) begin
          wr_act_reg <= 1'b0;
        end
      end
    end
  end

  // Masked lanes keep the stored value; a lane is a nybble or a byte by organization.
  for (genvar l = 0; l < MASK_W; l++) begin : g_lane
    assign wr_word[l*LANE_W +: LANE_W] = bus.byte_lane_mask_b[l] ?
      mem[wr_addr][l*LANE_W +: LANE_W] : bus.shared_data_pins[l*LANE_W +: LANE_W];
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_word;
    end
  end

  // The loop is held off while its pin is low and relocks after release.
  dbs_dll_t dll_state_reg;
  logic [DLL_CNT_W-1:0] dll_cnt_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dll_state_reg <= DLL_OFF;
      dll_cnt_reg <= '0;
    end else if (!bus.delay_loop_off_b) begin
      dll_state_reg <= DLL_OFF;
      dll_cnt_reg <= '0;
    end else begin
      case (dll_state_reg)
        DLL_OFF: begin
          dll_state_reg <= DLL_LOCKING;
        end
        DLL_LOCKING: begin
          dll_cnt_reg <= dll_cnt_reg + DLL_CNT_W'(1);
          if (dll_cnt_reg == DLL_CNT_W'(DLL_LOCK_CYCLES - 1)) begin
            dll_state_reg <= DLL_LOCKED;
          end
        end
        default: begin
          dll_state_reg <= DLL_LOCKED;
        end
      endcase
    end
  end

  assign dll_locked = (dll_state_reg == DLL_LOCKED);
endmodule
`default_nettype wire

//--- hw/dbs_pkg.sv
// Shared constants and types for the burst SRAM device model and its memory controller.
// Assumes both ends run on one system clock and meet in dbs_bus_if.
package dbs_pkg;
  // Narrow organization by default; medium and wide depths kept for other builds.
  localparam int DATA_W = 8;
  localparam int MASK_W = 2;
  localparam int WORDS_X36 = 524288;
  localparam int WORDS_X18 = 1048576;
  localparam int WORDS_X8 = 2097152;
  localparam int ADDR_W = 21;
  localparam int BURST_LEN = 4;
  localparam int BEAT_W = 2;
  // Edge counts between a captured command and its first data beat.
  localparam int RD_LEAD_EDGES = 3;
  localparam int WR_LEAD_EDGES = 2;
  // Widths of the write and read shift registers, and cycles from command cycle to first read beat seen.
  localparam int WR_SR_W = 5;
  localparam int RD_SR_W = 8;
  localparam int RD_FIRST_CYCLE = 4;
  localparam int DLL_LOCK_CYCLES = 1024;
  localparam int DLL_CNT_W = 11;
  // Least spacing in clock cycles between two commands on the pins.
  localparam logic [2:0] GAP_READ = 3'h4;
  localparam logic [2:0] GAP_WRITE = 3'h6;
  localparam logic [2:0] GAP_MAX = 3'h7;
  localparam logic [2:0] GAP_ONE = 3'h1;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    DLL_OFF = 2'b00,
    DLL_LOCKING = 2'b01,
    DLL_LOCKED = 2'b11
  } dbs_dll_t;
endpackage

//--- hw/dbs_bus_if.sv
// Pins between the burst SRAM device and its memory controller.
// The shared data wire is resolved here from the two drivers and their enables.
`timescale 1ns/1ps
`default_nettype none
interface dbs_bus_if #(
  parameter int DATA_W = dbs_pkg::DATA_W,
  parameter int MASK_W = dbs_pkg::MASK_W,
  parameter int ADDR_W = dbs_pkg::ADDR_W
);
  logic main_input_p;
  logic main_input_n;
  logic output_timing_p;
  logic output_timing_n;
  logic echo_strobe_p;
  logic echo_strobe_n;
  logic delay_loop_off_b;
  logic load_strobe_b;
  logic read_write_select;
  logic [ADDR_W-1:0] address_pins;
  logic [MASK_W-1:0] byte_lane_mask_b;
  logic [DATA_W-1:0] data_ctl_o;
  logic data_ctl_oe;
  logic [DATA_W-1:0] data_dev_o;
  logic data_dev_oe;
  logic [DATA_W-1:0] shared_data_pins;

  // An undriven bus reads as zero; the device wins if both ever drive.
  assign shared_data_pins = data_dev_oe ? data_dev_o : (data_ctl_oe ? data_ctl_o : '0);

  modport dev (
    input main_input_p, main_input_n, output_timing_p, output_timing_n,
    input delay_loop_off_b, load_strobe_b, read_write_select, address_pins,
    input byte_lane_mask_b, shared_data_pins,
    output echo_strobe_p, echo_strobe_n, data_dev_o, data_dev_oe
  );
  modport ctl (
    output main_input_p, main_input_n, output_timing_p, output_timing_n,
    output delay_loop_off_b, load_strobe_b, read_write_select, address_pins,
    output byte_lane_mask_b, data_ctl_o, data_ctl_oe,
    input echo_strobe_p, echo_strobe_n, shared_data_pins
  );
endinterface
`default_nettype wire

//--- hw/dbs_mem_ctl.sv
// Memory controller end: drives clocks, commands and write bursts, gathers read bursts.
// Assumes a single clk_sys; the device end samples these pins on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dbs_mem_ctl #(
  parameter int DATA_W = dbs_pkg::DATA_W,
  parameter int MASK_W = dbs_pkg::MASK_W,
  parameter int ADDR_W = dbs_pkg::ADDR_W,
  parameter bit SINGLE_CLK = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  dbs_bus_if.ctl bus,
  input wire logic dll_enable,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [dbs_pkg::BURST_LEN*DATA_W-1:0] cmd_wr_data,
  input wire logic [dbs_pkg::BURST_LEN*MASK_W-1:0] cmd_wr_mask_b,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [dbs_pkg::BURST_LEN*DATA_W-1:0] rd_data
);
  import dbs_pkg::*;

  localparam int PTR_W = $clog2(BUF_DEPTH);
  localparam int CNT_W = PTR_W + 1;

  logic ph_reg;
  logic [2:0] gap_reg;
  logic slot;
  logic credit_ok;
  logic issue;
  logic [CNT_W-1:0] outst_reg;
  logic [CNT_W-1:0] cnt_reg;

  // Commands go out only on the cycle in which the main clock rises.
  assign slot = ~ph_reg;
  assign credit_ok = (outst_reg + cnt_reg) < CNT_W'(BUF_DEPTH);
  assign cmd_ready = slot & (cmd_read ? (gap_reg >= GAP_READ) & credit_ok : (gap_reg >= GAP_WRITE));
  assign issue = cmd_valid & cmd_ready;

  assign bus.main_input_p = ph_reg;
  assign bus.main_input_n = ~ph_reg;
  assign bus.output_timing_p = SINGLE_CLK | ph_reg;
  assign bus.output_timing_n = SINGLE_CLK | ~ph_reg;

  logic load_b_reg;
  logic rw_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic dll_off_b_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ph_reg <= 1'b0;
      gap_reg <= GAP_MAX;
      load_b_reg <= 1'b1;
      rw_reg <= 1'b1;
      addr_reg <= '0;
      dll_off_b_reg <= 1'b0;
    end else begin
      ph_reg <= ~ph_reg;
      dll_off_b_reg <= dll_enable;
      load_b_reg <= ~issue;
      if (issue) begin
        gap_reg <= GAP_ONE;
        rw_reg <= cmd_read;
        // The narrow part refuses odd start addresses, so the lowest bit is forced even.
        addr_reg <= (DATA_W == 8) ? {cmd_addr[ADDR_W-1:1], 1'b0} : cmd_addr;
      end else if (gap_reg != GAP_MAX) begin
        gap_reg <= gap_reg + 3'h1;
      end
    end
  end

  assign bus.load_strobe_b = load_b_reg;
  assign bus.read_write_select = rw_reg;
  assign bus.address_pins = addr_reg;
  assign bus.delay_loop_off_b = dll_off_b_reg;

  // Write beats sit on the pins from the second through the fifth cycle after the command.
  logic [WR_SR_W-1:0] wsr_reg;
  logic [BURST_LEN*DATA_W-1:0] wbuf_reg;
  logic [BURST_LEN*MASK_W-1:0] wmask_reg;
  logic [DATA_W-1:0] dq_o_reg;
  logic dq_oe_reg;
  logic [MASK_W-1:0] mask_b_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wsr_reg <= '0;
      wbuf_reg <= '0;
      wmask_reg <= '1;
      dq_o_reg <= '0;
      dq_oe_reg <= 1'b0;
      mask_b_reg <= '1;
    end else begin
      wsr_reg <= {wsr_reg[WR_SR_W-2:0], issue & ~cmd_read};
      if (issue & ~cmd_read) begin
        wbuf_reg <= cmd_wr_data;
        wmask_reg <= cmd_wr_mask_b;
      end
      dq_oe_reg <= 1'b0;
      mask_b_reg <= '1;
      for (int k = 1; k < WR_SR_W; k++) begin
        if (wsr_reg[k]) begin
          dq_oe_reg <= 1'b1;
          dq_o_reg <= wbuf_reg[(k-1)*DATA_W +: DATA_W];
          mask_b_reg <= wmask_reg[(k-1)*MASK_W +: MASK_W];
        end
      end
    end
  end

  assign bus.data_ctl_o = dq_o_reg;
  assign bus.data_ctl_oe = dq_oe_reg;
  assign bus.byte_lane_mask_b = mask_b_reg;

  // Read beats are taken on echo clock edges inside the expected window.
  logic [RD_SR_W-1:0] rsr_reg;
  logic cq_d_reg;
  logic echo_edge;
  logic [BURST_LEN*DATA_W-1:0] rasm_reg;
  logic push_reg;

  assign echo_edge = bus.echo_strobe_p ^ cq_d_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rsr_reg <= '0;
      cq_d_reg <= 1'b0;
      rasm_reg <= '0;
      push_reg <= 1'b0;
    end else begin
      rsr_reg <= {rsr_reg[RD_SR_W-2:0], issue & cmd_read};
      cq_d_reg <= bus.echo_strobe_p;
      push_reg <= rsr_reg[RD_SR_W-1] & echo_edge;
      for (int k = RD_FIRST_CYCLE; k < RD_SR_W; k++) begin
        if (rsr_reg[k] & echo_edge) begin
          rasm_reg[(k-RD_FIRST_CYCLE)*DATA_W +: DATA_W] <= bus.shared_data_pins;
        end
      end
    end
  end

  // Reads are issued only against free buffer entries, so a stalled reader loses no burst.
  logic [BURST_LEN*DATA_W-1:0] buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0] wptr_reg;
  logic [PTR_W-1:0] rptr_reg;
  logic pop;

  assign rd_valid = (cnt_reg != '0);
  assign rd_data = buf_mem[rptr_reg];
  assign pop = rd_valid & rd_ready;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      outst_reg <= '0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem[i] <= '0;
      end
    end else begin
      outst_reg <= outst_reg + CNT_W'(issue & cmd_read) - CNT_W'(push_reg);
      cnt_reg <= cnt_reg + CNT_W'(push_reg) - CNT_W'(pop);
      if (push_reg) begin
        buf_mem[wptr_reg] <= rasm_reg;
        wptr_reg <= (wptr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : wptr_reg + PTR_W'(1);
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : rptr_reg + PTR_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/dbs_bus_monitor.sv
// Concurrent checks on the pins joining the burst SRAM device and its controller.
// Assumes one clock domain and the narrow organization, where the lowest burst bit is aligned.
`timescale 1ns/1ps
`default_nettype none
module dbs_bus_monitor #(
  parameter int ADDR_W = dbs_pkg::ADDR_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic main_input_p,
  input wire logic main_input_n,
  input wire logic output_timing_p,
  input wire logic output_timing_n,
  input wire logic echo_strobe_p,
  input wire logic echo_strobe_n,
  input wire logic load_strobe_b,
  input wire logic read_write_select,
  input wire logic [ADDR_W-1:0] address_pins,
  input wire logic data_ctl_oe,
  input wire logic data_dev_oe
);
  import dbs_pkg::*;
  logic [1:0] warm_reg;
  logic sel_clk;
  logic rd_cmd;

  // The echo pipeline needs a few edges after reset before $past sees real clock history.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      warm_reg <= 2'h0;
    end else if (warm_reg != 2'h3) begin
      warm_reg <= warm_reg + 2'h1;
    end
  end
  assign sel_clk = (output_timing_p & output_timing_n) ? main_input_p : output_timing_p;
  assign rd_cmd = !load_strobe_b && read_write_select;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_main_comp;
    main_input_p != main_input_n;
  endproperty
  a_main_comp: assert property (p_main_comp) else $error("main clock pair not complementary");
  property p_echo_comp;
    echo_strobe_p != echo_strobe_n;
  endproperty
  a_echo_comp: assert property (p_echo_comp) else $error("echo pair not complementary");
  property p_echo_run;
    warm_reg == 2'h3 |-> echo_strobe_p != $past(echo_strobe_p);
  endproperty
  a_echo_run: assert property (p_echo_run) else $error("echo clock stopped");
  property p_echo_src;
    warm_reg == 2'h3 |-> echo_strobe_p == $past(sel_clk);
  endproperty
  a_echo_src: assert property (p_echo_src) else $error("echo not following output clock");
  property p_load_pulse;
    !load_strobe_b |=> load_strobe_b [*3];
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("commands spaced too closely");
  property p_load_phase;
    !load_strobe_b |-> main_input_p;
  endproperty
  a_load_phase: assert property (p_load_phase) else $error("command not at main clock rise");
  property p_align;
    !load_strobe_b |-> !address_pins[0];
  endproperty
  a_align: assert property (p_align) else $error("burst start not aligned");
  property p_read_burst;
    rd_cmd |-> ##4 data_dev_oe [*4];
  endproperty
  a_read_burst: assert property (p_read_burst) else $error("read burst not four beats");
  property p_oe_cause;
    $rose(data_dev_oe) |-> $past(rd_cmd, 4);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("device drove without a read");
  property p_write_beats;
    !load_strobe_b && !read_write_select |-> ##2 data_ctl_oe [*4] ##1 !data_ctl_oe;
  endproperty
  a_write_beats: assert property (p_write_beats) else $error("write beats misplaced");
  property p_no_clash;
    !(data_dev_oe && data_ctl_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
endmodule
`default_nettype wire

//--- tb/ddr_burst_sram_read_port_tb.sv
// Self-checking bench: controller and device joined by the bus interface, with a memory model.
// Assumes a small array of 16 words and inputs changed on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_sram_read_port_tb;
  import dbs_pkg::*;
  logic clk_sys, rst_b, dll_enable, cmd_valid, cmd_read, rd_ready, stall;
  logic cmd_ready, rd_valid, dll_locked, single_clk_mode;
  logic [3:0] cmd_addr;
  logic [31:0] cmd_wr_data, rd_data;
  logic [7:0] cmd_wr_mask_b, seed;
  // The ready stream has its own generator, so it is seeded here and written only by its process.
  logic [7:0] rdy_seed = 8'h58;
  logic [7:0] mem_model [16];
  logic [31:0] exp_q[$];
  int fail_count, cmp_count, n;

  dbs_bus_if #(.ADDR_W(4)) bus ();
  dbs_sram_dev #(.DEPTH(16), .ADDR_W(4)) i_dbs_sram_dev (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus),
    .dll_locked(dll_locked), .single_clk_mode(single_clk_mode));
  dbs_mem_ctl #(.ADDR_W(4)) i_dbs_mem_ctl (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus),
    .dll_enable(dll_enable), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_wr_data(cmd_wr_data), .cmd_wr_mask_b(cmd_wr_mask_b),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  dbs_bus_monitor #(.ADDR_W(4)) i_dbs_bus_monitor (.clk_sys(clk_sys), .rst_b(rst_b),
    .main_input_p(bus.main_input_p), .main_input_n(bus.main_input_n),
    .output_timing_p(bus.output_timing_p), .output_timing_n(bus.output_timing_n),
    .echo_strobe_p(bus.echo_strobe_p), .echo_strobe_n(bus.echo_strobe_n),
    .load_strobe_b(bus.load_strobe_b), .read_write_select(bus.read_write_select),
    .address_pins(bus.address_pins), .data_ctl_oe(bus.data_ctl_oe), .data_dev_oe(bus.data_dev_oe));

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] r32();
    logic [31:0] v;
    v = '0;
    repeat (4) begin
      seed = nxt(seed);
      v = {v[23:0], seed};
    end
    return v;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // The memory model is updated when the command is taken, since bursts complete in issue order.
  task automatic send(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [7:0] m);
    int k;
    logic [1:0] lo;
    logic [31:0] e;
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_wr_data = d;
    cmd_wr_mask_b = m;
    k = 0;
    #1;
    while (cmd_ready !== 1'b1 && k < 300) begin
      @(negedge clk_sys);
      #1;
      k++;
    end
    check("command taken", 1, k < 300);
    @(posedge clk_sys);
    e = '0;
    for (int i = 0; i < 4; i++) begin
      lo = a[1:0] + 2'(i);
      if (rd) e[i*8 +: 8] = mem_model[{a[3:2], lo}];
      for (int b = 0; b < 2; b++)
        if (!rd && !m[i*2+b]) mem_model[{a[3:2], lo}][b*4 +: 4] = d[i*8+b*4 +: 4];
    end
    if (rd) exp_q.push_back(e);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask

  // Waits, within a bound, until every expected read burst has been taken by the user side.
  task automatic drain;
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Random stalls by the user side exercise the two-entry read buffer.
  always @(negedge clk_sys) begin
    rdy_seed = nxt(rdy_seed);
    rd_ready <= !stall && rdy_seed[0];
  end

  always @(posedge clk_sys) begin
    if (rst_b === 1'b1 && rd_valid === 1'b1 && rd_ready === 1'b1) begin
      if (exp_q.size() == 0) check("unrequested burst", 0, 1);
      else check("read burst", exp_q.pop_front(), rd_data);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    final_report;
  end

  initial begin
    rst_b = 1'b0;
    dll_enable = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 4'h0;
    cmd_wr_data = 32'h0;
    cmd_wr_mask_b = 8'hff;
    stall = 1'b0;
    seed = 8'h58;
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (1100) @(negedge clk_sys);
    check("delay loop locked while off", 0, dll_locked);
    check("single clock mode", 0, single_clk_mode);
    dll_enable = 1'b1;
    repeat (1040) @(negedge clk_sys);
    check("delay loop locked", 1, dll_locked);
    for (int g = 0; g < 4; g++) send(1'b0, 4'(g * 4), r32(), 8'h00);
    repeat (6) send(1'b0, {seed[3:1], 1'b0}, r32(), nxt(seed));
    for (int g = 0; g < 8; g++) send(1'b1, 4'(g * 2), 32'h0, 8'hff);
    // Bursts still in flight would hold the buffer credits and block the two reads below.
    drain();
    check("reads drained before stall", 0, exp_q.size());
    stall = 1'b1;
    send(1'b1, 4'h2, 32'h0, 8'hff);
    send(1'b1, 4'he, 32'h0, 8'hff);
    repeat (30) @(negedge clk_sys);
    repeat (8) begin
      @(negedge clk_sys);
      check("ready while buffer full", 0, cmd_ready);
    end
    stall = 1'b0;
    repeat (6) send(1'b1, {seed[3:1], 1'b0}, r32(), 8'hff);
    drain();
    check("reads outstanding", 0, exp_q.size());
    final_report;
  end
endmodule
`default_nettype wire
